// File: rtl/gdc_gate_ctrl.sv
// Three-phase gate drive control: mode decode, dead time, windows, supplies
`timescale 1ns/1ps
module gdc_gate_ctrl #(
  parameter int DT_STEP_NS = 100 // Extra dead time per step of the select code
) (
  input wire logic clk_in, // 250 MHz internal clock
  input wire logic sys_rst_in, // Power-on reset, async, active high
  input wire logic vcc_good_in, // Supply above power-on threshold
  input wire logic enable_in, // Enable pin, high requests Operating
  input wire logic [2:0] hi_cmd_in, // High command per phase
  input wire logic [2:0] lo_cmd_in, // Low command per phase
  input wire logic [2:0] gh_below_in, // High gate below adaptive threshold
  input wire logic [2:0] gl_below_in, // Low gate below adaptive threshold
  input wire logic control_scheme_select_pin_in, // Mode strap, high = PWM
  input wire logic [2:0] drive_strength_strap_in, // Strap strength level
  input wire logic [1:0] dead_time_strap_in, // Strap extra dead time code
  input wire logic [3:0] avs_address_in, // Avalon byte address
  input wire logic avs_read_in, // Avalon read
  input wire logic avs_write_in, // Avalon write
  input wire logic [31:0] avs_writedata_in, // Avalon write data
  input wire logic [3:0] avs_byteenable_in, // Avalon byte enables
  output logic [31:0] avs_readdata_out, // Avalon read data
  output logic avs_waitrequest_out, // Avalon wait request
  output gdc_pkg::gdc_gate_s [2:0] high_gate_out, // High gate drive per phase
  output gdc_pkg::gdc_gate_s [2:0] low_gate_out, // Low gate drive per phase
  output gdc_pkg::gdc_pwr_s pwr_out // Supply block enables
);

  localparam int CW = gdc_pkg::CNT_W;

  // ==========================================================================
  // Parameter check
  if (3 * DT_STEP_NS * gdc_pkg::CLK_MHZ / 1000 >= 2 ** CW) begin : g_bad_dt
    $error("DT_STEP_NS too large for the dead time counter");
  end

  // ==========================================================================
  // Functions
  // Mode decode of one phase, returns {high wanted, low wanted}
  function automatic logic [1:0] cmd_decode(input logic pwm, input logic h,
                                            input logic l);
    if (pwm) begin
      cmd_decode = l ? {h, ~h} : 2'h0;
    end else begin
      cmd_decode = (h ^ l) ? {h, l} : 2'h0;
    end
  endfunction : cmd_decode

  function automatic logic [CW-1:0] tgt_cyc(input logic [1:0] sel);
    case (sel)
      2'h0: tgt_cyc = CW'(gdc_pkg::TGT_05_CYC);
      2'h1: tgt_cyc = CW'(gdc_pkg::TGT_1_CYC);
      2'h2: tgt_cyc = CW'(gdc_pkg::TGT_2_CYC);
      default: tgt_cyc = CW'(gdc_pkg::TGT_4_CYC);
    endcase
  endfunction : tgt_cyc

  // ==========================================================================
  // Pin synchronisers: two flops, only the second one is read
  logic [19:0] sync1_q;
  logic [19:0] sync2_q;
  logic s_vcc, s_en, s_mode;
  logic [1:0] s_dts;
  logic [2:0] s_drs, s_gh, s_gl, s_lo, s_hi;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1_q <= 20'h0;
      sync2_q <= 20'h0;
    end else begin
      sync1_q <= {vcc_good_in, enable_in, dead_time_strap_in, drive_strength_strap_in,
                  control_scheme_select_pin_in, gh_below_in, gl_below_in, lo_cmd_in,
                  hi_cmd_in};
      sync2_q <= sync1_q;
    end
  end

  assign {s_vcc, s_en, s_dts, s_drs, s_mode, s_gh, s_gl, s_lo, s_hi} = sync2_q;

  // ==========================================================================
  // Strap capture once after reset; later pin changes are not looked at
  logic [1:0] init_cnt_q;
  logic init_done_q;
  logic pwm_q;
  logic [2:0] drs_q;
  logic [1:0] dts_q;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      init_cnt_q <= 2'h0;
      init_done_q <= 1'b0;
      pwm_q <= 1'b0;
      drs_q <= 3'h0;
      dts_q <= 2'h0;
    end else if (!init_done_q) begin
      init_cnt_q <= init_cnt_q + 2'h1;
      if (init_cnt_q == gdc_pkg::INIT_CYC - 2'h1) begin
        init_done_q <= 1'b1;
        pwm_q <= s_mode;
        drs_q <= s_drs;
        dts_q <= s_dts;
      end
    end
  end

  // ==========================================================================
  // Power mode; the supply outputs follow it one cycle later
  gdc_pkg::gdc_pwr_mode_e pm_q, pm_d;
  gdc_pkg::gdc_pwr_s pwr_q;
  logic mode_op;

  always_comb begin
    if (!s_vcc) begin
      pm_d = gdc_pkg::PM_SHUTDOWN;
    end else if (!s_en) begin
      pm_d = gdc_pkg::PM_SLEEP;
    end else begin
      pm_d = gdc_pkg::PM_OPERATING;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pm_q <= gdc_pkg::PM_SHUTDOWN;
    end else begin
      pm_q <= pm_d;
    end
  end

  // Shutdown state is also the reset state, so the clamp holds the host rail
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pwr_q <= 7'b0010001;
    end else begin
      case (pm_q)
        gdc_pkg::PM_OPERATING: pwr_q <= 7'b1101100;
        gdc_pkg::PM_SLEEP: pwr_q <= 7'b0010110;
        default: pwr_q <= 7'b0010001;
      endcase
    end
  end

  assign mode_op = init_done_q && (pm_q == gdc_pkg::PM_OPERATING);

  // ==========================================================================
  // Configuration register and effective settings
  gdc_pkg::gdc_cfg_s cfg_q;
  logic [1:0] tgt_sel, dt_sel;
  logic [CW-1:0] cur_tgt, cur_dt;
  logic [3:0] hsrc, lsrc;

  assign tgt_sel = cfg_q.ser ? cfg_q.gate_transition_limit : gdc_pkg::TGT_RST_SEL;
  assign dt_sel = cfg_q.ser ? cfg_q.dt : dts_q;
  assign cur_tgt = tgt_cyc(tgt_sel);
  assign cur_dt = CW'(int'(dt_sel) * DT_STEP_NS * gdc_pkg::CLK_MHZ / 1000);
  assign hsrc = cfg_q.ser ? cfg_q.hsrc : {1'b0, drs_q};
  assign lsrc = cfg_q.ser ? cfg_q.lsrc : {1'b0, drs_q};

  // ==========================================================================
  // Per-phase gate state, window and dead time logic
  logic [2:0] hon_q, lon_q, hon_d, lon_d;
  logic [2:0] win_hi_q, win_up_q;
  logic [CW-1:0] win_q [3];
  logic [CW-1:0] dt_q [3];
  gdc_pkg::gdc_gate_s [2:0] hg_q, lg_q;

  for (genvar p = 0; p < 3; p++) begin : g_phase
    logic [1:0] want;
    logic h_up, h_dn, l_up, l_dn, tsns;

    assign want = mode_op ? cmd_decode(pwm_q, s_hi[p], s_lo[p]) : 2'h0;

    // A gate may start on only when partner is off, below threshold, gap elapsed
    always_comb begin
      hon_d[p] = want[1] && (hon_q[p] || (!lon_q[p] && s_gl[p] && dt_q[p] == '0));
      lon_d[p] = want[0] && (lon_q[p] || (!hon_q[p] && s_gh[p] && dt_q[p] == '0));
    end

    assign h_up = hon_d[p] && !hon_q[p];
    assign h_dn = !hon_d[p] && hon_q[p];
    assign l_up = lon_d[p] && !lon_q[p];
    assign l_dn = !lon_d[p] && lon_q[p];
    assign tsns = win_hi_q[p] ? s_gh[p] : s_gl[p];

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        hon_q[p] <= 1'b0;
        lon_q[p] <= 1'b0;
      end else begin
        hon_q[p] <= hon_d[p];
        lon_q[p] <= lon_d[p];
      end
    end

    // Window restarts on every edge of either gate, so a short on-time cuts it
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        win_q[p] <= '0;
        win_hi_q[p] <= 1'b0;
        win_up_q[p] <= 1'b0;
      end else if (h_up || h_dn || l_up || l_dn) begin
        win_q[p] <= cur_tgt;
        win_hi_q[p] <= h_up || h_dn;
        win_up_q[p] <= h_up || l_up;
      end else if (win_q[p] != '0) begin
        if (!win_up_q[p] && tsns) begin
          win_q[p] <= '0;
        end else begin
          win_q[p] <= win_q[p] - CW'(1);
        end
      end
    end

    // Extra gap counts once both gates are off and below threshold; a host
    // gap longer than it hides it completely
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        dt_q[p] <= '0;
      end else if (hon_q[p] || lon_q[p] || !s_gh[p] || !s_gl[p]) begin
        dt_q[p] <= cur_dt;
      end else if (dt_q[p] != '0) begin
        dt_q[p] <= dt_q[p] - CW'(1);
      end
    end

    // Drive commands, registered so every output comes from a flop
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        hg_q[p] <= '0;
        lg_q[p] <= '0;
      end else begin
        hg_q[p].on <= hon_q[p];
        hg_q[p].peak <= win_q[p] != '0 && win_hi_q[p];
        hg_q[p].strong_sink <= win_q[p] != '0 && !win_hi_q[p];
        hg_q[p].hold_up <= win_q[p] == '0 && hon_q[p];
        hg_q[p].hold_dn <= win_q[p] == '0 && !hon_q[p];
        hg_q[p].src <= hsrc;
        hg_q[p].snk <= {hsrc, 1'b0};
        lg_q[p].on <= lon_q[p];
        lg_q[p].peak <= win_q[p] != '0 && !win_hi_q[p];
        lg_q[p].strong_sink <= win_q[p] != '0 && win_hi_q[p];
        lg_q[p].hold_up <= win_q[p] == '0 && lon_q[p];
        lg_q[p].hold_dn <= win_q[p] == '0 && !lon_q[p];
        lg_q[p].src <= lsrc;
        lg_q[p].snk <= {lsrc, 1'b0};
      end
    end
  end

  // ==========================================================================
  // Avalon-MM slave: one wait cycle, read data ready when wait drops
  logic wait_q;
  logic [31:0] rdata_q, cfg_word, sts_word, wmask, wnew;

  always_comb begin
    cfg_word = 32'h0;
    cfg_word[gdc_pkg::CFG_SER_BIT] = cfg_q.ser;
    cfg_word[gdc_pkg::CFG_HSRC_LSB +: 4] = cfg_q.hsrc;
    cfg_word[gdc_pkg::CFG_LSRC_LSB +: 4] = cfg_q.lsrc;
    cfg_word[gdc_pkg::CFG_TGT_LSB +: 2] = cfg_q.gate_transition_limit;
    cfg_word[gdc_pkg::CFG_DT_LSB +: 2] = cfg_q.dt;
    sts_word = 32'h0;
    sts_word[gdc_pkg::STS_PWM_BIT] = pwm_q;
    sts_word[gdc_pkg::STS_INIT_BIT] = init_done_q;
    sts_word[gdc_pkg::STS_PM_LSB +: 2] = pm_q;
    sts_word[gdc_pkg::STS_HON_LSB +: 3] = hon_q;
    sts_word[gdc_pkg::STS_LON_LSB +: 3] = lon_q;
    wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
             {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    wnew = (cfg_word & ~wmask) | (avs_writedata_in & wmask);
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q <= !((avs_read_in || avs_write_in) && wait_q);
      if (avs_read_in && wait_q) begin
        if (avs_address_in == gdc_pkg::CFG_ADDR) begin
          rdata_q <= cfg_word;
        end else if (avs_address_in == gdc_pkg::STS_ADDR) begin
          rdata_q <= sts_word;
        end else begin
          rdata_q <= 32'h0;
        end
      end
    end
  end

  // Config commits at the edge where wait is seen low
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_q <= {1'b0, gdc_pkg::SRC_RST, gdc_pkg::SRC_RST, gdc_pkg::TGT_RST_SEL,
                gdc_pkg::DT_RST};
    end else if (avs_write_in && !wait_q && avs_address_in == gdc_pkg::CFG_ADDR) begin
      cfg_q.ser <= wnew[gdc_pkg::CFG_SER_BIT];
      cfg_q.hsrc <= wnew[gdc_pkg::CFG_HSRC_LSB +: 4];
      cfg_q.lsrc <= wnew[gdc_pkg::CFG_LSRC_LSB +: 4];
      cfg_q.gate_transition_limit <= wnew[gdc_pkg::CFG_TGT_LSB +: 2];
      cfg_q.dt <= wnew[gdc_pkg::CFG_DT_LSB +: 2];
    end
  end

  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out = rdata_q;
  assign high_gate_out = hg_q;
  assign low_gate_out = lg_q;
  assign pwr_out = pwr_q;

  // ==========================================================================
  // Assertions on phase 0 and the shared logic, plus sleep and sink checks on phases 1 and 2
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_indep_both;
    mode_op && !pwm_q && s_hi[0] && s_lo[0] |=> !hon_q[0] && !lon_q[0];
  endproperty
  a_indep_both: assert property (p_indep_both) else $error("both gates not off");

  property p_pwm_disable;
    mode_op && pwm_q && !s_lo[0] |=> !hon_q[0] && !lon_q[0];
  endproperty
  a_pwm_disable: assert property (p_pwm_disable) else $error("disabled phase drives");

  property p_sleep_off;
    !mode_op |=> hon_q == 3'h0 && lon_q == 3'h0 ##1 !high_gate_out[1].on;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("gate on outside Operating");

  property p_sink_double;
    ##1 low_gate_out[2].snk == {$past(lsrc), 1'b0};
  endproperty
  a_sink_double: assert property (p_sink_double) else $error("sink not twice source");

  property p_win_load;
    !hon_q[0] && hon_d[0] |=> win_q[0] == $past(cur_tgt) && win_up_q[0];
  endproperty
  a_win_load: assert property (p_win_load) else $error("window not loaded");

  property p_strong_sink;
    win_q[0] != '0 && win_hi_q[0] |=> low_gate_out[0].strong_sink && !low_gate_out[0].hold_dn;
  endproperty
  a_strong_sink: assert property (p_strong_sink) else $error("no strong sink");

  property p_adaptive;
    $rose(hon_q[0]) |-> $past(s_gl[0]) && !$past(lon_q[0]) && $past(dt_q[0]) == '0;
  endproperty
  a_adaptive: assert property (p_adaptive) else $error("turn-on before partner low");

  property p_early_end;
    win_q[0] != '0 && !win_up_q[0] && (win_hi_q[0] ? s_gh[0] : s_gl[0])
      |=> win_q[0] == '0 || win_up_q[0];
  endproperty
  a_early_end: assert property (p_early_end) else $error("turn-off window kept");

  property p_run_supply;
    pm_q == gdc_pkg::PM_OPERATING |=> pwr_out.run_reg_en && !pwr_out.standby_reg_en
      && pwr_out.buck_boost_en && pwr_out.host_reg_en;
  endproperty
  a_run_supply: assert property (p_run_supply) else $error("bad Operating supplies");

  property p_mode_frozen;
    init_done_q |=> $stable(pwm_q) [*8];
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed after capture");

  c_turn_on: cover property ($rose(hg_q[0].on));
  c_early: cover property (win_q[0] != '0 && !win_up_q[0] ##1 win_q[0] == '0);
  c_sleep: cover property (pm_q == gdc_pkg::PM_SLEEP ##1 pm_q == gdc_pkg::PM_OPERATING);

endmodule : gdc_gate_ctrl

// File: include/gdc_pkg.sv
// Shared constants and types of the three-phase gate drive control block
package gdc_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int CNT_W = 11;
  // Gate transition window choices in ns; a longest time, so cycles round down
  localparam int TGT_05_NS = 500;
  localparam int TGT_1_NS = 1000;
  localparam int TGT_2_NS = 2000;
  localparam int TGT_4_NS = 4000;
  localparam int TGT_05_CYC = TGT_05_NS * CLK_MHZ / 1000;
  localparam int TGT_1_CYC = TGT_1_NS * CLK_MHZ / 1000;
  localparam int TGT_2_CYC = TGT_2_NS * CLK_MHZ / 1000;
  localparam int TGT_4_CYC = TGT_4_NS * CLK_MHZ / 1000;
  // Cycles from reset release until the straps are latched (sync depth + 1)
  localparam logic [1:0] INIT_CYC = 2'h3;

  // ==========================================================================
  // Register map (byte addresses) and field layout
  localparam logic [3:0] CFG_ADDR = 4'h0;
  localparam logic [3:0] STS_ADDR = 4'h4;
  localparam int CFG_SER_BIT = 0;
  localparam int CFG_HSRC_LSB = 4;
  localparam int CFG_LSRC_LSB = 8;
  localparam int CFG_TGT_LSB = 12;
  localparam int CFG_DT_LSB = 16;
  localparam int STS_PWM_BIT = 0;
  localparam int STS_INIT_BIT = 1;
  localparam int STS_PM_LSB = 2;
  localparam int STS_HON_LSB = 4;
  localparam int STS_LON_LSB = 8;
  localparam logic [1:0] TGT_RST_SEL = 2'h1;
  localparam logic [3:0] SRC_RST = 4'h0;
  localparam logic [1:0] DT_RST = 2'h0;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {PM_SHUTDOWN, PM_SLEEP, PM_OPERATING} gdc_pwr_mode_e;

  typedef struct packed {
    logic ser;
    logic [3:0] hsrc;
    logic [3:0] lsrc;
    logic [1:0] gate_transition_limit;
    logic [1:0] dt;
  } gdc_cfg_s;

  typedef struct packed {
    logic on;
    logic peak;
    logic strong_sink;
    logic hold_up;
    logic hold_dn;
    logic [3:0] src;
    logic [4:0] snk;
  } gdc_gate_s;

  typedef struct packed {
    logic buck_boost_en;
    logic charge_pump_en;
    logic standby_reg_en;
    logic run_reg_en;
    logic host_reg_en;
    logic host_reg_low_power;
    logic host_clamp_en;
  } gdc_pwr_s;

endpackage : gdc_pkg

// File: tb/gdc_gate_sense_model.sv
// Far-side model: gate voltage sensing of the six external switches
`timescale 1ns/1ps
module gdc_gate_sense_model (
  input wire logic clk_in, // Block clock
  input wire logic [5:0] on_in, // Gate on levels, low gates in the upper half
  input wire logic [7:0] delay_in, // Discharge time in cycles, prompt or slow
  output logic [5:0] below_out // Gate below the adaptive threshold
);
  // ==========================================================================
  // Discharge counters
  logic [7:0] cnt_q [6];
  logic [5:0] below_q = 6'h3F;
  assign below_out = below_q;

  // A driven gate leaves the threshold at once; a released one sinks after delay_in
  // cycles, so a slow delay shows whether turn-on really waits for it
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 6; i++) begin
      if (on_in[i]) begin
        cnt_q[i] <= 8'h00;
        below_q[i] <= 1'b0;
      end else if (cnt_q[i] >= delay_in) begin
        below_q[i] <= 1'b1;
      end else begin
        cnt_q[i] <= cnt_q[i] + 8'h01;
      end
    end
  end
endmodule : gdc_gate_sense_model

// File: tb/gdc_gate_ctrl_bench.sv
// Self-checking bench for the three-phase gate drive control block
`timescale 1ns/1ps
module gdc_gate_ctrl_bench;
  // ==========================================================================
  // Signals
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic vcc_good = 1'b0;
  logic enable = 1'b0;
  logic sel_pin = 1'b0;
  logic [2:0] hi_cmd = 3'h0;
  logic [2:0] lo_cmd = 3'h0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] r;
  logic wait_req;
  logic [5:0] below;
  logic [5:0] gate_on;
  logic [7:0] sense_delay = 8'h05;
  gdc_pkg::gdc_gate_s [2:0] hg;
  gdc_pkg::gdc_gate_s [2:0] lg;
  gdc_pkg::gdc_pwr_s pwr;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;

  // Gate on levels gathered for the sense model and the checks
  assign gate_on = {lg[2].on, lg[1].on, lg[0].on, hg[2].on, hg[1].on, hg[0].on};

  // ==========================================================================
  // Design and far side
  gdc_gate_ctrl uut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .vcc_good_in(vcc_good),
    .enable_in(enable), .hi_cmd_in(hi_cmd), .lo_cmd_in(lo_cmd),
    .gh_below_in(below[2:0]), .gl_below_in(below[5:3]),
    .control_scheme_select_pin_in(sel_pin), .drive_strength_strap_in(3'h5),
    .dead_time_strap_in(2'h1), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
    .high_gate_out(hg), .low_gate_out(lg), .pwr_out(pwr)
  );
  gdc_gate_sense_model sense (
    .clk_in(clk_in), .on_in(gate_on), .delay_in(sense_delay), .below_out(below)
  );

  // ==========================================================================
  // Clock and hang guard; the whole run needs well under 5000 cycles
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // ==========================================================================
  // Tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : chk_rng

  // Avalon access: request held until waitrequest is sampled low
  // Only the bench's cycle ceiling ends a wait that never completes
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk_in);
    end while (wait_req !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task cmd(input logic [2:0] h, input logic [2:0] l);
    @(posedge clk_in);
    hi_cmd <= h;
    lo_cmd <= l;
    @(posedge clk_in);
  endtask : cmd

  // Bounded wait for a gate pattern; n returns the cycles taken
  task wait_gate(input logic [5:0] exp, input int lim);
    n = 0;
    while (gate_on !== exp && n < lim) begin
      @(posedge clk_in);
      n++;
    end
  endtask : wait_gate

  task do_reset(input logic mode);
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    sel_pin <= mode;
    hi_cmd <= 3'h0;
    lo_cmd <= 3'h0;
    repeat (10) @(posedge clk_in);
    chk(pwr, 32'h11);
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
  endtask : do_reset

  task close_out();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // Test sequence
  initial begin
    do_reset(1'b0);
    repeat (10) @(posedge clk_in);
    chk(pwr, 32'h11);
    vcc_good <= 1'b1;
    cmd(3'h7, 3'h0);
    repeat (30) @(posedge clk_in);
    chk(pwr, 32'h16);
    chk(gate_on, 32'h0);
    bus(1'b0, gdc_pkg::STS_ADDR, 32'h0);
    chk(r & 32'hF, 32'h6);
    bus(1'b0, gdc_pkg::CFG_ADDR, 32'h0);
    chk(r, 32'h1000);
    bus(1'b0, 4'h8, 32'h0);
    chk(r, 32'h0);
    enable <= 1'b1;
    cmd(3'h0, 3'h0);
    repeat (30) @(posedge clk_in);
    chk(pwr, 32'h6C);
    chk({hg[0].src, hg[0].snk, lg[2].src, lg[2].snk}, {4'h5, 5'h0A, 4'h5, 5'h0A});
    // Independent control truth table on all phases at once
    for (int c = 0; c < 4; c++) begin
      cmd({3{c[1]}}, {3{c[0]}});
      wait_gate({{3{c == 1}}, {3{c == 2}}}, 150);
      chk(gate_on, {{3{c == 1}}, {3{c == 2}}});
    end
    // Turn-on window runs full length, then hold drive takes over
    cmd(3'h7, 3'h0);
    wait_gate(6'h07, 150);
    repeat (200) @(posedge clk_in);
    chk({hg[1].peak, lg[1].strong_sink}, 32'h3);
    repeat (60) @(posedge clk_in);
    chk({hg[1].peak, hg[1].hold_up, lg[1].strong_sink, lg[1].hold_dn}, 32'h5);
    // Short host gap: adaptive wait plus strap gap of 25 cycles
    // Turn-off window must already be over while the extra gap still runs
    cmd(3'h0, 3'h7);
    repeat (20) @(posedge clk_in);
    chk({hg[0].peak, lg[0].strong_sink, hg[0].hold_dn}, 32'h1);
    wait_gate(6'h38, 150);
    chk_rng(n, 10, 30);
    // Long host gap: turn-on follows the command promptly
    cmd(3'h0, 3'h0);
    repeat (300) @(posedge clk_in);
    cmd(3'h7, 3'h0);
    wait_gate(6'h07, 150);
    chk_rng(n, 1, 8);
    // Select pin moved after capture has no effect
    sel_pin <= 1'b1;
    cmd(3'h7, 3'h7);
    repeat (100) @(posedge clk_in);
    chk(gate_on, 32'h0);
    bus(1'b0, gdc_pkg::STS_ADDR, 32'h0);
    chk(r & 32'h1, 32'h0);
    // PWM-with-enable control after a fresh reset
    do_reset(1'b1);
    repeat (10) @(posedge clk_in);
    bus(1'b0, gdc_pkg::STS_ADDR, 32'h0);
    chk(r & 32'hF, 32'hB);
    for (int c = 0; c < 4; c++) begin
      cmd({3{c[1]}}, {3{c[0]}});
      wait_gate({{3{c == 1}}, {3{c == 3}}}, 150);
      chk(gate_on, {{3{c == 1}}, {3{c == 3}}});
    end
    // Serial path: separate sources, 0.5us window, gap code 2
    bus(1'b1, gdc_pkg::CFG_ADDR, 32'h000203A1);
    bus(1'b1, 4'hC, 32'hFFFFFFFF);
    bus(1'b0, gdc_pkg::CFG_ADDR, 32'h0);
    chk(r & 32'h00033FF1, 32'h000203A1);
    chk({hg[2].src, hg[2].snk, lg[2].src, lg[2].snk}, {4'hA, 5'h14, 4'h3, 5'h06});
    sense_delay <= 8'h02;
    cmd(3'h0, 3'h7);
    wait_gate(6'h38, 150);
    chk_rng(n, 50, 72);
    repeat (100) @(posedge clk_in);
    chk({lg[0].peak, hg[0].strong_sink}, 32'h3);
    repeat (30) @(posedge clk_in);
    chk({lg[0].peak, lg[0].hold_up, hg[0].strong_sink, hg[0].hold_dn}, 32'h5);
    // Slow discharge of the partner gate delays the turn-on
    sense_delay <= 8'h28;
    cmd(3'h7, 3'h7);
    wait_gate(6'h07, 200);
    chk_rng(n, 90, 115);
    close_out();
  end
endmodule : gdc_gate_ctrl_bench
